// *** rtl/safety_mon_defs.svh ***
`ifndef SAFETY_MON_DEFS_SVH
`define SAFETY_MON_DEFS_SVH

// ----------------------------------------------------------------------
// Clock and timebase
// ----------------------------------------------------------------------
`define CLK_NS 25
`define MS_NS 1000000
`define MS_CYC (`MS_NS / `CLK_NS)
`define PULSE_NS 50000
`define PULSE_CYC ((`PULSE_NS + `CLK_NS - 1) / `CLK_NS)

// ----------------------------------------------------------------------
// Filter and discrepancy settings
// ----------------------------------------------------------------------
`define FILT_STEP_MS 12'h019
`define FILT_MAX_STEPS 6'h28
`define FILT_DEF_STEPS 6'h00
`define DISC_STEP_MS 12'h032
`define DISC_MAX_STEPS 6'h3C
`define DISC_DEF_STEPS 6'h02
`define MS_TMR_MAX 12'hFFF

// ----------------------------------------------------------------------
// Output test spacing and fault indication
// ----------------------------------------------------------------------
`define MAIN_GAP_MS 8'h7D
`define OUT_GAP_MS 8'hFA
`define FLASH_HALF_MS 8'hFA
`define FAULT_TYPE_MINOR 8'h10
`define CODE_CHAN 8'h08
`define CODE_DISC 8'h20
`define CODE_NONE 8'h00

`endif

// *** rtl/safety_mon_pkg.sv ***
package safety_mon_pkg;

  // Monitor function progress
  typedef enum logic [1:0] {
    S_OFF,
    S_ARMED,
    S_ON
  } mon_state_t;

  // Output tester position in its endless cycle
  typedef enum logic [1:0] {
    T_MAIN0,
    T_MAIN1,
    T_OUT
  } tst_step_t;

endpackage : safety_mon_pkg

// *** rtl/dual_channel_safety_monitor.sv ***
`timescale 1ns/10ps
`include "safety_mon_defs.svh"

module dual_channel_safety_monitor #(
  parameter int N_OUT = 4,
  parameter int MS_CYCLES = `MS_CYC
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic chan_a_in,
  input wire logic chan_b_in,
  input wire logic two_input_mode,
  input wire logic cfg_load,
  input wire logic [5:0] filter_steps,
  input wire logic [5:0] disc_steps,
  input wire logic [N_OUT-1:0] out_request,
  input wire logic [N_OUT-1:0] out_test_en,
  output logic monitor_function_output,
  output logic chan_fault,
  output logic disc_fault,
  output logic fault_led,
  output logic [7:0] fault_type,
  output logic [7:0] fault_code,
  output logic [N_OUT-1:0] safety_out,
  output logic test_pulse_active
);

  localparam int IDX_W = (N_OUT > 1) ? $clog2(N_OUT) : 1;
  localparam int MS_W = $clog2(MS_CYCLES + 1);
  localparam int PULSE_LEN = `PULSE_CYC;
  localparam logic [11:0] PULSE_LAST = 12'(`PULSE_CYC - 1);
  localparam logic [MS_W-1:0] MS_LAST = MS_W'(MS_CYCLES - 1);

  // ----------------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------------

  // Configured time in ms from a step count
  function automatic logic [11:0] ms_limit(input logic [5:0] steps, input logic [11:0] step_ms);
    logic [11:0] r;
    r = 12'(steps * step_ms);
    return r;
  endfunction : ms_limit

  // Lowest enabled output above 'from'; top bit flags that one was found
  function automatic logic [IDX_W:0] next_en(input logic [N_OUT-1:0] en, input int from);
    logic [IDX_W:0] r;
    r = '0;
    for (int i = N_OUT - 1; i >= 0; i--) begin
      if (i > from && en[i]) begin
        r = {1'b1, IDX_W'(i)};
      end
    end
    return r;
  endfunction : next_en

  // ----------------------------------------------------------------------
  // Millisecond timebase
  // ----------------------------------------------------------------------
  logic [MS_W-1:0] ms_cnt_q;
  logic ms_tick_q;

  // Single tick shared by all millisecond timers so they stay in step
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      ms_cnt_q <= '0;
      ms_tick_q <= 1'b0;
    end else begin
      ms_tick_q <= (ms_cnt_q == MS_LAST);
      ms_cnt_q <= (ms_cnt_q == MS_LAST) ? '0 : ms_cnt_q + 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Configuration capture
  // ----------------------------------------------------------------------
  logic [5:0] filt_cfg_q;
  logic [5:0] disc_cfg_q;
  logic two_in_q;

  // Out-of-range settings clamp to the largest legal step count
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      filt_cfg_q <= `FILT_DEF_STEPS;
      disc_cfg_q <= `DISC_DEF_STEPS;
      two_in_q <= 1'b1;
    end else if (cfg_load) begin
      filt_cfg_q <= (filter_steps > `FILT_MAX_STEPS) ? `FILT_MAX_STEPS : filter_steps;
      disc_cfg_q <= (disc_steps > `DISC_MAX_STEPS) ? `DISC_MAX_STEPS : disc_steps;
      two_in_q <= two_input_mode;
    end
  end

  wire logic [11:0] filt_lim_w = ms_limit(filt_cfg_q, `FILT_STEP_MS);
  wire logic [11:0] disc_lim_w = ms_limit(disc_cfg_q, `DISC_STEP_MS);
  // Checks only exist for two-input functions with a nonzero time
  wire logic chk_en_w = two_in_q && (disc_cfg_q != 6'h00);

  // ----------------------------------------------------------------------
  // Input sampling, filter and discrepancy timers
  // ----------------------------------------------------------------------
  logic a_q;
  logic b_q;
  logic [11:0] filt_ms_q;
  logic [11:0] mism_ms_q;

  // Single-input mode mirrors channel A so no mismatch can arise
  wire logic b_eff_w = two_in_q ? b_q : a_q;
  wire logic chg_w = (chan_a_in != a_q) || (two_in_q && (chan_b_in != b_q));
  wire logic both_hi_w = a_q && b_eff_w;
  wire logic both_lo_w = !a_q && !b_eff_w;
  wire logic mism_w = a_q != b_eff_w;
  wire logic stable_w = !chg_w && (filt_ms_q >= filt_lim_w);

  // Every edge on A, or on B in two-input mode, restarts the filter; the mismatch timer runs only while inputs differ
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      a_q <= 1'b0;
      b_q <= 1'b0;
      filt_ms_q <= 12'h000;
      mism_ms_q <= 12'h000;
    end else begin
      a_q <= chan_a_in;
      b_q <= chan_b_in;
      if (chg_w) begin
        filt_ms_q <= 12'h000;
      end else if (ms_tick_q && filt_ms_q != `MS_TMR_MAX) begin
        filt_ms_q <= filt_ms_q + 12'h001;
      end
      if (!mism_w) begin
        mism_ms_q <= 12'h000;
      end else if (ms_tick_q && mism_ms_q != `MS_TMR_MAX) begin
        mism_ms_q <= mism_ms_q + 12'h001;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Monitor state machine and faults
  // ----------------------------------------------------------------------
  safety_mon_pkg::mon_state_t state_q;
  safety_mon_pkg::mon_state_t state_d;
  logic drop_pend_q;
  logic chan_flt_q;
  logic disc_flt_q;

  // Lone return high after a filtered drop is a channel fault
  wire logic chan_set_w = chk_en_w && drop_pend_q && both_hi_w
                          && (state_q == safety_mon_pkg::S_OFF);
  wire logic disc_set_w = chk_en_w && mism_w && (mism_ms_q >= disc_lim_w);
  wire logic flt_set_w = chan_set_w || disc_set_w;
  wire logic rise_w = (state_q == safety_mon_pkg::S_ARMED) && stable_w && both_hi_w && !flt_set_w;
  wire logic drop_w = (state_q == safety_mon_pkg::S_ON) && stable_w && !both_hi_w;

  // Output is only re-armed by a full low cycle, so a lone drop needs both inputs cycled
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      safety_mon_pkg::S_OFF: begin
        if (stable_w && both_lo_w) begin
          state_d = safety_mon_pkg::S_ARMED;
        end
      end
      safety_mon_pkg::S_ARMED: begin
        if (rise_w) begin
          state_d = safety_mon_pkg::S_ON;
        end else if (flt_set_w) begin
          // A lagging contact may trail until the discrepancy time runs out
          state_d = safety_mon_pkg::S_OFF;
        end
      end
      safety_mon_pkg::S_ON: begin
        if (flt_set_w) begin
          state_d = safety_mon_pkg::S_OFF;
        end else if (drop_w) begin
          state_d = both_lo_w ? safety_mon_pkg::S_ARMED : safety_mon_pkg::S_OFF;
        end
      end
    endcase
  end

  // Set wins over clear so a fault arriving at the re-arm edge is kept
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      state_q <= safety_mon_pkg::S_OFF;
      drop_pend_q <= 1'b0;
      chan_flt_q <= 1'b0;
      disc_flt_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if (drop_w && mism_w) begin
        drop_pend_q <= 1'b1;
      end else if (both_lo_w || chan_set_w) begin
        drop_pend_q <= 1'b0;
      end
      chan_flt_q <= chan_set_w || (chan_flt_q && !rise_w);
      disc_flt_q <= disc_set_w || (disc_flt_q && !rise_w);
    end
  end

  // ----------------------------------------------------------------------
  // Fault indication and report
  // ----------------------------------------------------------------------
  logic [7:0] flash_ms_q;
  logic flash_q;

  wire logic chan_d_w = chan_set_w || (chan_flt_q && !rise_w);
  wire logic disc_d_w = disc_set_w || (disc_flt_q && !rise_w);
  wire logic [7:0] code_w = (chan_d_w ? `CODE_CHAN : `CODE_NONE)
                            | (disc_d_w ? `CODE_DISC : `CODE_NONE);

  // Free-running blink so every fault shows the same flash rate
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      flash_ms_q <= 8'h00;
      flash_q <= 1'b0;
      monitor_function_output <= 1'b0;
      chan_fault <= 1'b0;
      disc_fault <= 1'b0;
      fault_led <= 1'b0;
      fault_type <= 8'h00;
      fault_code <= 8'h00;
    end else begin
      if (ms_tick_q) begin
        flash_ms_q <= (flash_ms_q >= `FLASH_HALF_MS - 8'h01) ? 8'h00 : flash_ms_q + 8'h01;
        flash_q <= (flash_ms_q >= `FLASH_HALF_MS - 8'h01) ? !flash_q : flash_q;
      end
      monitor_function_output <= (state_d == safety_mon_pkg::S_ON);
      chan_fault <= chan_d_w;
      disc_fault <= disc_d_w;
      fault_led <= (chan_flt_q || disc_flt_q) && flash_q;
      fault_type <= (chan_d_w || disc_d_w) ? `FAULT_TYPE_MINOR : `CODE_NONE;
      fault_code <= code_w;
    end
  end

  // ----------------------------------------------------------------------
  // Output test sequencer
  // ----------------------------------------------------------------------
  safety_mon_pkg::tst_step_t step_q;
  logic rep_q;
  logic [IDX_W-1:0] cur_q;
  logic [7:0] gap_ms_q;
  logic pulse_on_q;
  logic pulse_main_q;
  logic [IDX_W-1:0] pulse_idx_q;
  logic [11:0] pulse_cnt_q;

  wire logic [IDX_W:0] first_w = next_en(out_test_en, -1);
  wire logic [IDX_W:0] after_w = next_en(out_test_en, int'(cur_q));
  wire logic [7:0] target_w = (step_q == safety_mon_pkg::T_MAIN1) ? `MAIN_GAP_MS
                                                                  : `OUT_GAP_MS;
  wire logic fire_w = !pulse_on_q && (gap_ms_q >= target_w);
  wire logic pulse_end_w = pulse_on_q && (pulse_cnt_q == PULSE_LAST);

  // Step order: main, main, then two pulses per enabled output, then back
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      step_q <= safety_mon_pkg::T_MAIN0;
      rep_q <= 1'b0;
      cur_q <= '0;
      gap_ms_q <= 8'h00;
      pulse_main_q <= 1'b0;
      pulse_idx_q <= '0;
    end else if (fire_w) begin
      gap_ms_q <= 8'h00;
      pulse_main_q <= (step_q != safety_mon_pkg::T_OUT);
      pulse_idx_q <= cur_q;
      unique case (step_q)
        safety_mon_pkg::T_MAIN0: begin
          step_q <= safety_mon_pkg::T_MAIN1;
        end
        safety_mon_pkg::T_MAIN1: begin
          step_q <= first_w[IDX_W] ? safety_mon_pkg::T_OUT : safety_mon_pkg::T_MAIN0;
          cur_q <= first_w[IDX_W-1:0];
          rep_q <= 1'b0;
        end
        safety_mon_pkg::T_OUT: begin
          if (!rep_q) begin
            rep_q <= 1'b1;
          end else begin
            rep_q <= 1'b0;
            cur_q <= after_w[IDX_W-1:0];
            step_q <= after_w[IDX_W] ? safety_mon_pkg::T_OUT : safety_mon_pkg::T_MAIN0;
          end
        end
      endcase
    end else if (ms_tick_q && gap_ms_q != 8'hFF) begin
      gap_ms_q <= gap_ms_q + 8'h01;
    end
  end

  // Pulse width counted in system clocks; a pulse is far shorter than one tick
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      pulse_on_q <= 1'b0;
      pulse_cnt_q <= 12'h000;
    end else if (fire_w) begin
      pulse_on_q <= 1'b1;
      pulse_cnt_q <= 12'h000;
    end else if (pulse_end_w) begin
      pulse_on_q <= 1'b0;
    end else if (pulse_on_q) begin
      pulse_cnt_q <= pulse_cnt_q + 12'h001;
    end
  end

  // Main pulse blanks every output, an individual pulse only its own
  wire logic [N_OUT-1:0] one_hot_w = N_OUT'(1) << pulse_idx_q;
  wire logic [N_OUT-1:0] mask_w = !pulse_on_q ? '0 : (pulse_main_q ? '1 : one_hot_w);

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      safety_out <= '0;
      test_pulse_active <= 1'b0;
    end else begin
      safety_out <= out_request & ~mask_w;
      test_pulse_active <= pulse_on_q;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  a_main_all_off: assert property (@(posedge sys_clk) disable iff (!rstn)
    pulse_on_q && pulse_main_q |=> safety_out == '0)
    else $error("Main test pulse left an output on");

  a_indiv_one_off: assert property (@(posedge sys_clk) disable iff (!rstn)
    pulse_on_q && !pulse_main_q |=> !safety_out[$past(pulse_idx_q)])
    else $error("Individual test pulse missed its output");

  a_pulse_length: assert property (@(posedge sys_clk) disable iff (!rstn)
    $fell(pulse_on_q) |-> $past(pulse_cnt_q) == 12'(PULSE_LEN - 1))
    else $error("Test pulse width wrong");

  a_rise_stable: assert property (@(posedge sys_clk) disable iff (!rstn)
    $rose(monitor_function_output) |-> $past(both_hi_w && stable_w))
    else $error("Output rose without stable high inputs");

  a_fault_forces_off: assert property (@(posedge sys_clk) disable iff (!rstn)
    (chan_fault || disc_fault) |-> !monitor_function_output)
    else $error("Output high while a fault is latched");

  a_check_disabled: assert property (@(posedge sys_clk) disable iff (!rstn)
    !chk_en_w |=> !$rose(chan_flt_q) && !$rose(disc_flt_q))
    else $error("Fault raised with checks disabled");

  a_disc_timeout: assert property (@(posedge sys_clk) disable iff (!rstn)
    $rose(disc_flt_q) |-> $past(mism_ms_q) >= $past(disc_lim_w) && $past(mism_w))
    else $error("Discrepancy fault before the time expired");

  a_filter_drop: assert property (@(posedge sys_clk) disable iff (!rstn)
    state_q == safety_mon_pkg::S_ON && stable_w && !both_hi_w |=> !monitor_function_output)
    else $error("Output stayed high after filtered drop");

  a_code_chan: assert property (@(posedge sys_clk) disable iff (!rstn)
    chan_fault && !disc_fault |-> fault_type == 8'h10 && fault_code == 8'h08)
    else $error("Channel fault report wrong");

  a_code_disc: assert property (@(posedge sys_clk) disable iff (!rstn)
    disc_fault && !chan_fault |-> fault_type == 8'h10 && fault_code == 8'h20)
    else $error("Discrepancy fault report wrong");

endmodule : dual_channel_safety_monitor

// *** verification/contact_pair_model.sv ***
`timescale 1ns/10ps

// ------------------------------------------------------------
// Two-contact safety switch on the far side of the monitor
// ------------------------------------------------------------
module contact_pair_model (
  input wire logic sys_clk,
  input wire logic want_a,
  input wire logic want_b,
  input wire logic slow_b,
  output logic chan_a,
  output logic chan_b
);
  logic [2:0] lag_q;

  // Contact B may trail A by a few cycles, far inside the discrepancy time
  always_ff @(posedge sys_clk) begin
    lag_q <= {lag_q[1:0], want_b};
    chan_a <= want_a;
    chan_b <= slow_b ? lag_q[2] : want_b;
  end
endmodule : contact_pair_model

// *** verification/dual_channel_safety_monitor_bench.sv ***
`timescale 1ns/10ps
`include "safety_mon_defs.svh"
`define CHK(g, e) check_val((g), (e))

module dual_channel_safety_monitor_bench;
  localparam int MSC = 40;
  localparam int F = 2 * 25 * MSC;
  localparam int D = 2 * 50 * MSC;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic want_a = 1'b0;
  logic want_b = 1'b0;
  logic slow_b = 1'b0;
  logic chan_a, chan_b, fault_led, test_pulse_active;
  logic two_input_mode = 1'b1;
  logic cfg_load = 1'b0;
  logic [5:0] filter_steps = 6'h00;
  logic [5:0] disc_steps = 6'h02;
  logic [3:0] out_request = 4'hF;
  logic [3:0] out_test_en = 4'h0;
  logic monitor_function_output, chan_fault, disc_fault;
  logic [7:0] fault_type, fault_code;
  logic [3:0] safety_out;
  int bad_count = 0;
  int n_checks = 0;
  int seed = 32'hC30E;
  int cyc = 0;
  int last = 0;
  int width = 0;
  int k = 0;
  int n_en = 0;
  int en_list[4];
  logic prev = 1'b0;
  logic flt_prev = 1'b0;

  // Free-running 40 MHz clock
  always #12.5 sys_clk = ~sys_clk;

  contact_pair_model PARTNER (.sys_clk(sys_clk), .want_a(want_a), .want_b(want_b),
    .slow_b(slow_b), .chan_a(chan_a), .chan_b(chan_b));

  dual_channel_safety_monitor #(.N_OUT(4), .MS_CYCLES(MSC)) DUT (.sys_clk(sys_clk),
    .rstn(rstn), .chan_a_in(chan_a), .chan_b_in(chan_b), .two_input_mode(two_input_mode),
    .cfg_load(cfg_load), .filter_steps(filter_steps), .disc_steps(disc_steps),
    .out_request(out_request), .out_test_en(out_test_en),
    .monitor_function_output(monitor_function_output), .chan_fault(chan_fault),
    .disc_fault(disc_fault), .fault_led(fault_led), .fault_type(fault_type),
    .fault_code(fault_code), .safety_out(safety_out), .test_pulse_active(test_pulse_active));

  // ------------------------------------------------------------
  // Shared tasks and expectations
  // ------------------------------------------------------------
  task automatic check_val(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value at %0t: got %0h expected %0h", $time, g, e);
    end
  endtask : check_val

  // Ends just after an edge so outputs have settled
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick

  task automatic drive(input logic a, input logic b, input int n);
    @(posedge sys_clk);
    want_a <= a;
    want_b <= b;
    tick(n);
  endtask : drive

  task automatic load_cfg(input logic [5:0] f, input logic [5:0] d, input logic two);
    @(posedge sys_clk);
    filter_steps <= f;
    disc_steps <= d;
    two_input_mode <= two;
    cfg_load <= 1'b1;
    @(posedge sys_clk);
    cfg_load <= 1'b0;
  endtask : load_cfg

  // Both low past the filter, then both high; contact lag picked at random
  task automatic recycle();
    @(posedge sys_clk);
    slow_b <= 1'($random(seed));
    drive(1'b0, 1'b0, F + 200);
    drive(1'b1, 1'b1, F + 200);
  endtask : recycle

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask : done

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish

  function automatic logic [3:0] exp_mask(input int i);
    if (i < 2 || i >= 2 + 2 * n_en) return 4'hF;
    return 4'h1 << en_list[(i - 2) / 2];
  endfunction : exp_mask

  function automatic int exp_gap(input int i);
    return (i == 1) ? `MAIN_GAP_MS * MSC : `OUT_GAP_MS * MSC;
  endfunction : exp_gap

  // ------------------------------------------------------------
  // Output tester watcher, runs beside every scenario
  // ------------------------------------------------------------
  // Reads pre-edge values, so it never races the design's own updates
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    prev <= test_pulse_active;
    // Indicator lags the latched fault by one register stage
    flt_prev <= chan_fault || disc_fault;
    if (fault_led) `CHK(flt_prev, 1);
    if (test_pulse_active) width <= width + 1;
    if (test_pulse_active && !prev) begin
      if (k < 3 + 2 * n_en) begin
        `CHK(4'(~safety_out), exp_mask(k));
        if (k > 0) `CHK((cyc - last) inside {[exp_gap(k) - 1 : exp_gap(k) + 1]}, 1);
      end
      k <= k + 1;
      last <= cyc;
      width <= 1;
    end
    if (!test_pulse_active && prev) `CHK(width, `PULSE_CYC);
  end

  // Watchdog sized well beyond the expected run of about 70k cycles
  initial begin
    repeat (100000) @(posedge sys_clk);
    bad_count++;
    tally_and_finish();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    int i, j;
    i = $unsigned($random(seed)) % 4;
    j = $unsigned($random(seed)) % 4;
    out_test_en = (4'h1 << i) | (4'h1 << j);
    for (int b = 0; b < 4; b++) begin
      if (out_test_en[b]) begin
        en_list[n_en] = b;
        n_en++;
      end
    end
    repeat (4) @(posedge sys_clk);
    rstn <= 1'b1;
    tick(1);
    `CHK({monitor_function_output, chan_fault, disc_fault}, 3'b000);
    // Defaults: no filter, discrepancy of two steps
    drive(1'b0, 1'b0, 4);
    drive(1'b1, 1'b1, 6);
    `CHK(monitor_function_output, 1);
    drive(1'b0, 1'b1, D - 100);
    `CHK(disc_fault, 0);
    tick(200);
    `CHK({disc_fault, fault_type, fault_code}, {1'b1, 8'h10, 8'h20});
    recycle();
    `CHK({disc_fault, monitor_function_output}, 2'b01);
    done("defaults");
    load_cfg(6'h02, 6'h02, 1'b1);
    recycle();
    // Random lone glitches, all shorter than the filter time
    for (int r = 0; r < 4; r++) begin
      drive(1'b1, 1'b0, 100 + $unsigned($random(seed)) % (F - 300));
      drive(1'b1, 1'b1, 10);
    end
    tick(F);
    `CHK({monitor_function_output, chan_fault}, 2'b10);
    for (int r = 0; r < 3; r++) begin
      drive(1'b0, 1'b0, 300);
      drive(1'b1, 1'b1, 300);
    end
    `CHK(monitor_function_output, 1);
    drive(1'b1, 1'b0, F - 100);
    `CHK(monitor_function_output, 1);
    tick(200);
    `CHK(monitor_function_output, 0);
    drive(1'b1, 1'b1, F);
    `CHK({chan_fault, disc_fault, fault_type, fault_code}, {2'b10, 8'h10, 8'h08});
    drive(1'b0, 1'b0, F + 200);
    drive(1'b1, 1'b0, 500);
    drive(1'b0, 1'b0, F + 200);
    `CHK({monitor_function_output, chan_fault}, 2'b01);
    drive(1'b1, 1'b1, F - 200);
    `CHK(monitor_function_output, 0);
    tick(300);
    `CHK({monitor_function_output, chan_fault, fault_code}, {2'b10, 8'h00});
    done("filter and channel");
    // A drop outlasting the discrepancy time
    drive(1'b0, 1'b1, D + 500);
    drive(1'b1, 1'b1, F + 100);
    `CHK({chan_fault, disc_fault, fault_code}, {2'b11, 8'h28});
    // Faults stay latched, so the blinking indicator must light within one period
    for (int w = 0; w < 20000 && !fault_led; w++) tick(1);
    `CHK(fault_led, 1);
    recycle();
    `CHK({chan_fault, disc_fault, monitor_function_output, fault_led}, 4'b0010);
    drive(1'b0, 1'b0, F + 200);
    drive(1'b0, 1'b1, D + 500);
    `CHK(disc_fault, 1);
    recycle();
    `CHK(disc_fault, 0);
    done("discrepancy");
    load_cfg(6'h02, 6'h00, 1'b1);
    drive(1'b1, 1'b0, F + 500);
    drive(1'b1, 1'b1, F + 100);
    `CHK({chan_fault, disc_fault}, 2'b00);
    load_cfg(6'h02, 6'h02, 1'b0);
    recycle();
    drive(1'b1, 1'b0, D + 500);
    `CHK({monitor_function_output, chan_fault, disc_fault}, 3'b100);
    drive(1'b0, 1'b0, F + 200);
    `CHK(monitor_function_output, 0);
    done("config");
    for (int w = 0; w < 80000 && k < 3 + 2 * n_en; w++) tick(1);
    `CHK(k >= 3 + 2 * n_en, 1);
    done("output tester");
    tally_and_finish();
  end
endmodule : dual_channel_safety_monitor_bench
